/* frs_pkg.sv */
// Package for fault reaction and self-test select logic
package frs_pkg;
  localparam int          FRS_NSRC         = 5;
  localparam int          FRS_SRC_OV       = 1;
  localparam int          FRS_SRC_DOP      = 0;
  localparam logic        FRS_REG_SUP      = 1'h0;
  localparam logic        FRS_REG_AMP      = 1'h1;
  localparam logic [7:0]  FRS_SUP_MASK     = 8'he6;
  localparam logic [7:0]  FRS_AMP_MASK     = 8'h7f;
  localparam logic [7:0]  FRS_SEL_RESET    = 8'h00;
  localparam logic [1:0]  FRS_CAP_WARN     = 2'h0;
  localparam logic [1:0]  FRS_CAP_LATCH    = 2'h3;
  localparam logic [2:0]  FRS_OV_WARN      = 3'h0;
  localparam logic [2:0]  FRS_OV_ERR       = 3'h1;
  localparam logic [2:0]  FRS_OV_ARE       = 3'h2;
  localparam logic [2:0]  FRS_OV_LE        = 3'h3;
  localparam logic [2:0]  FRS_OV_ARE_HS    = 3'h6;
  localparam logic [2:0]  FRS_OV_LE_HS     = 3'h7;
  localparam int          FRS_CLK_NS       = 25;
  localparam int          FRS_EXT_TIME_NS  = 1000;
  localparam int          FRS_EXT_CYCLES   = (FRS_EXT_TIME_NS + FRS_CLK_NS - 1) / FRS_CLK_NS;
  localparam int          FRS_EXT_W        = 8;

  typedef struct packed {
    logic [2:0][1:0] capUvCode;
    logic [2:0]      ovCode;
    logic            dopCode;
  } frs_cfg_s;

  typedef struct packed {
    logic [2:0] capUv;
    logic       ov;
    logic       dop;
  } frs_det_s;

  typedef struct packed {
    logic [2:0] highOff;
    logic [2:0] lowOff;
  } frs_fet_s;
endpackage

/* frs_fault_reaction.sv */
// Fault reaction, status flags, fault pin and self-test selection
module frs_fault_reaction
  import frs_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Pins
  input  wire logic             driverEnablePin,
  output logic                  faultPinN,
  // Failure configuration and detectors
  input  wire frs_cfg_s         cfg,
  input  wire frs_det_s         det,
  // Failure status
  input  wire logic             failRegRead,
  output logic [FRS_NSRC-1:0]   failReg,
  output logic                  warnFlag,
  output logic                  errFlag,
  output frs_fet_s              fetOff,
  // Self-test mode from entry sequence checker
  input  wire logic             selftestMode,
  // Register access
  input  wire logic             regWrite,
  input  wire logic             regSel,
  input  wire logic [7:0]       regWdata,
  output logic [7:0]            regRdata,
  // Self-test outputs
  output logic [7:0]            activeSupTest,
  output logic [7:0]            activeAmpTest,
  output logic [2:0]            ampEnable
);

  // Highest set bit wins: bit 7 first, matching the priority order
  function automatic logic [7:0] pickTop(input logic [7:0] req);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (req[i]) begin
        res = 8'h00;
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction

  // Failure register index of capacitor monitor c; capacitor 0 sits on top
  function automatic int capIdx(input int c);
    return FRS_NSRC - 1 - c;
  endfunction

  logic [2:0]            enaSync_r;
  logic                  enaLevel_r;
  logic [FRS_NSRC-1:0]   detVec;
  logic [FRS_NSRC-1:0]   isErr;
  logic [FRS_NSRC-1:0]   isLatch;
  logic [FRS_NSRC-1:0]   latch_r;
  logic [FRS_NSRC-1:0]   pinLow;
  logic [FRS_NSRC-1:0]   restartOff;
  logic [FRS_EXT_W-1:0]  extCnt_r [FRS_NSRC];
  logic [7:0]            selSup_r;
  logic [7:0]            selAmp_r;
  logic [7:0]            ampTop;
  logic [2:0]            ampUnderTest;
  logic                  ovHighOff;
  logic                  ovLowOff;
  logic                  dopAllOff;

  // Failure register order: capacitor 0 on top, output pin at bit 0
  assign detVec = {det.capUv[0], det.capUv[1], det.capUv[2], det.ov, det.dop};

  // Enable pin sync; level taken once the last two stages agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enaSync_r <= 3'h0;
    end else begin
      enaSync_r <= {enaSync_r[1:0], driverEnablePin};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enaLevel_r <= 1'b0;
    end else if (enaSync_r[1] == enaSync_r[2]) begin
      enaLevel_r <= enaSync_r[2];
    end
  end

  // Per-source behaviour decode; index 4..2 capacitors, 1 supply, 0 output pin
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      isErr[capIdx(i)]      = cfg.capUvCode[i] != FRS_CAP_WARN;
      isLatch[capIdx(i)]    = cfg.capUvCode[i] == FRS_CAP_LATCH;
      restartOff[capIdx(i)] = cfg.capUvCode[i][1] && !isLatch[capIdx(i)];
    end
    // Unlisted supply codes 100 and 101 raise an error only
    isErr[FRS_SRC_OV]      = cfg.ovCode != FRS_OV_WARN;
    isLatch[FRS_SRC_OV]    = cfg.ovCode == FRS_OV_LE || cfg.ovCode == FRS_OV_LE_HS;
    restartOff[FRS_SRC_OV] = cfg.ovCode == FRS_OV_ARE || cfg.ovCode == FRS_OV_ARE_HS;
    isErr[FRS_SRC_DOP]      = 1'b1;
    isLatch[FRS_SRC_DOP]    = cfg.dopCode;
    restartOff[FRS_SRC_DOP] = 1'b0;
  end

  // Independent reaction per source
  generate
    for (genvar s = 0; s < FRS_NSRC; s++) begin : g_src
      // Set wins over the enable-pin clear
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          latch_r[s] <= 1'b0;
        end else if (detVec[s] && isLatch[s]) begin
          latch_r[s] <= 1'b1;
        end else if (!enaLevel_r) begin
          latch_r[s] <= 1'b0;
        end
      end

      // Extension timer reloads while an error-type failure is present
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          extCnt_r[s] <= '0;
        end else if (detVec[s] && isErr[s]) begin
          extCnt_r[s] <= FRS_EXT_W'(FRS_EXT_CYCLES);
        end else if (extCnt_r[s] != '0) begin
          extCnt_r[s] <= extCnt_r[s] - FRS_EXT_W'(1);
        end
      end

      // Sticky failure bit; set wins over the read clear
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          failReg[s] <= 1'b0;
        end else if (detVec[s]) begin
          failReg[s] <= 1'b1;
        end else if (failRegRead) begin
          failReg[s] <= 1'b0;
        end
      end

      assign pinLow[s] = latch_r[s] || (isErr[s] && (detVec[s] || extCnt_r[s] != '0));
    end
  endgenerate

  // Supply and output-pin reactions reach every half bridge
  assign ovHighOff = (restartOff[FRS_SRC_OV] || isLatch[FRS_SRC_OV]) && pinLow[FRS_SRC_OV];
  assign ovLowOff  = ovHighOff && !cfg.ovCode[2];
  assign dopAllOff = isLatch[FRS_SRC_DOP] && latch_r[FRS_SRC_DOP];

  // Pin and summary flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      faultPinN <= 1'b1;
      warnFlag  <= 1'b0;
      errFlag   <= 1'b0;
    end else begin
      faultPinN <= ~|pinLow;
      warnFlag  <= |(failReg & ~isErr);
      errFlag   <= |(failReg & isErr);
    end
  end

  // FET shut-off; self-tests never touch the output stages
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fetOff <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        fetOff.highOff[i] <= (latch_r[capIdx(i)] || (restartOff[capIdx(i)] && pinLow[capIdx(i)]))
                             || ovHighOff
                             || dopAllOff;
        fetOff.lowOff[i]  <= ovLowOff
                             || dopAllOff;
      end
    end
  end

  // Select registers: writes only in self-test mode, cleared outside it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      selSup_r <= FRS_SEL_RESET;
      selAmp_r <= FRS_SEL_RESET;
    end else if (!selftestMode) begin
      selSup_r <= FRS_SEL_RESET;
      selAmp_r <= FRS_SEL_RESET;
    end else if (regWrite && regSel == FRS_REG_SUP) begin
      selSup_r <= regWdata & FRS_SUP_MASK;
    end else if (regWrite && regSel == FRS_REG_AMP) begin
      selAmp_r <= regWdata & FRS_AMP_MASK;
    end
  end

  // Read path follows the register select one cycle later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= (regSel == FRS_REG_SUP) ? selSup_r : selAmp_r;
    end
  end

  // Gain test pairs: bits 2:1 amplifier 1, 4:3 amplifier 2, 6:5 amplifier 3
  always_comb begin
    ampTop = pickTop(selAmp_r);
    for (int a = 0; a < 3; a++) begin
      ampUnderTest[a] = ampTop[2 * a + 1] || ampTop[2 * a + 2];
    end
  end

  // One test at a time; supervision register ahead of amplifier register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      activeSupTest <= 8'h00;
      activeAmpTest <= 8'h00;
      ampEnable     <= 3'h7;
    end else begin
      activeSupTest <= pickTop(selSup_r);
      activeAmpTest <= (selSup_r != 8'h00) ? 8'h00 : ampTop;
      ampEnable     <= (selSup_r != 8'h00) ? 3'h7 : ~ampUnderTest;
    end
  end

endmodule // frs_fault_reaction

/* frs_fault_reaction_monitor.sv */
// Assertion checker for the fault reaction ports
module frs_fault_reaction_monitor
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic                mclk,
  input wire logic                resetn,
  // Observed ports
  input wire logic                faultPinN,
  input wire frs_cfg_s            cfg,
  input wire frs_det_s            det,
  input wire logic [FRS_NSRC-1:0] failReg,
  input wire logic                warnFlag,
  input wire logic                errFlag,
  input wire frs_fet_s            fetOff,
  input wire logic                selftestMode,
  input wire logic                regSel,
  input wire logic [7:0]          regRdata,
  input wire logic [7:0]          activeSupTest,
  input wire logic [7:0]          activeAmpTest
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ov_latch_off: assert property (det.ov && cfg.ovCode == FRS_OV_LE |-> ##2 !faultPinN && fetOff == 6'h3f)
    else $error("ov latch");
  a_ov_warn: assert property (det.ov && cfg.ovCode == FRS_OV_WARN |-> ##2 warnFlag)
    else $error("ov warn");
  a_cap_hs_off: assert property (det.capUv[0] && cfg.capUvCode[0] == FRS_CAP_LATCH |-> ##2 fetOff.highOff[0])
    else $error("cap latch");
  a_dop_err: assert property (det.dop |-> ##2 errFlag)
    else $error("dop err");
  a_dop_all_off: assert property (det.dop && cfg.dopCode |-> ##2 fetOff == 6'h3f)
    else $error("dop off");
  a_ext_pin_hold: assert property (det.dop |-> ##2 !faultPinN [*8])
    else $error("pin hold");
  a_both_sticky: assert property (det.ov && det.capUv[0] |=> failReg[1] && failReg[4])
    else $error("parallel");
  a_reserved_zero: assert property (!$past(regSel) |-> (regRdata & ~FRS_SUP_MASK) == 8'h00)
    else $error("reserved");
  a_mode_gate: assert property (!selftestMode [*2] |=> activeSupTest == 8'h00 && activeAmpTest == 8'h00)
    else $error("mode gate");
  a_single_test: assert property ($onehot0({activeSupTest, activeAmpTest}))
    else $error("one test");
  c_latch: cover property (det.ov && cfg.ovCode == FRS_OV_LE);
  c_amp: cover property (activeAmpTest != 8'h00);
  c_release: cover property ($rose(faultPinN));
endmodule // frs_fault_reaction_monitor

bind frs_fault_reaction frs_fault_reaction_monitor mon (.mclk, .resetn, .faultPinN, .cfg, .det, .failReg,
  .warnFlag, .errFlag, .fetOff, .selftestMode, .regSel, .regRdata, .activeSupTest, .activeAmpTest);

/* frs_host_model.sv */
// Host controller model for register, mode and enable lines
module frs_host_model
  import frs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Host lines
  output logic       driverEnablePin,
  output logic       failRegRead,
  output logic       selftestMode,
  output logic       regWrite,
  output logic       regSel,
  output logic [7:0] regWdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {driverEnablePin, failRegRead, selftestMode, regWrite, regSel, regWdata} = {1'h1, 12'h000};
  end
  // Mode flag stands for a completed entry sequence
  task setMode(input logic m);
    @(posedge mclk);
    selftestMode <= m;
  endtask
  // One select write at a time
  task wr(input logic s, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'h1;
    regSel <= s;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'h0;
  endtask
  task pick(input logic s);
    @(posedge mclk);
    regSel <= s;
    repeat (2) @(posedge mclk);
  endtask
  task readFail;
    @(posedge mclk);
    failRegRead <= 1'h1;
    @(posedge mclk);
    failRegRead <= 1'h0;
  endtask
  task enaPulse;
    @(posedge mclk);
    driverEnablePin <= 1'h0;
    repeat (6) @(posedge mclk);
    driverEnablePin <= 1'h1;
    repeat (6) @(posedge mclk);
  endtask
endmodule // frs_host_model

/* test_frs_fault_reaction.sv */
// Self-checking bench for the fault reaction block
module test_frs_fault_reaction
  import frs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  frs_cfg_s cfg = 10'h000;
  frs_det_s det = 5'h00;
  logic driverEnablePin, failRegRead, selftestMode, regWrite, regSel, faultPinN, warnFlag, errFlag;
  logic [7:0] regWdata, regRdata, activeSupTest, activeAmpTest;
  logic [4:0] failReg;
  logic [2:0] ampEnable;
  frs_fet_s fetOff;
  int miscompares = 0;
  int checkCount = 0;
  frs_host_model host (.mclk, .driverEnablePin, .failRegRead, .selftestMode, .regWrite, .regSel, .regWdata);
  frs_fault_reaction uut (.mclk, .resetn, .driverEnablePin, .faultPinN, .cfg, .det, .failRegRead, .failReg,
    .warnFlag, .errFlag, .fetOff, .selftestMode, .regWrite, .regSel, .regWdata, .regRdata, .activeSupTest,
    .activeAmpTest, .ampEnable);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task rd(input logic s, input logic [7:0] e);
    host.pick(s);
    #1;
    chk(regRdata, e);
  endtask
  // m: warning type in bit 1, latched type in bit 0
  task fault(input frs_cfg_s c, input frs_det_s d, input logic [4:0] fr, input logic [1:0] m, input frs_fet_s f);
    @(posedge mclk);
    cfg <= c;
    det <= d;
    repeat (3) @(posedge mclk);
    #1;
    chk({failReg, faultPinN, warnFlag, errFlag, fetOff}, {fr, m[1], m[1], !m[1], f});
    host.readFail;
    @(posedge mclk);
    det <= 5'h00;
    repeat (20) @(posedge mclk);
    #1;
    chk(faultPinN, m[1]);
    repeat (28) @(posedge mclk);
    #1;
    chk({faultPinN, errFlag, fetOff}, {!m[0], !m[1], m[0] ? f : 6'h00});
    host.readFail;
    host.enaPulse;
    #1;
    chk({failReg, faultPinN, errFlag, fetOff}, {5'h00, 1'h1, 1'h0, 6'h00});
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    #1;
    chk({failReg, faultPinN, warnFlag, errFlag, fetOff, ampEnable}, {5'h00, 3'h4, 6'h00, 3'h7});
    host.wr(FRS_REG_SUP, 8'hff);
    rd(FRS_REG_SUP, 8'h00);
    host.setMode(1'h1);
    host.wr(FRS_REG_SUP, 8'hff);
    rd(FRS_REG_SUP, 8'he6);
    chk({activeSupTest, ampEnable}, {8'h80, 3'h7});
    host.wr(FRS_REG_AMP, 8'hff);
    rd(FRS_REG_AMP, 8'h7f);
    host.wr(FRS_REG_SUP, 8'h00);
    for (int i = 0; i < 7; i++) begin
      host.wr(FRS_REG_AMP, 8'hff >> (7 - i));
      repeat (2) @(posedge mclk);
      #1;
      chk({activeAmpTest, ampEnable}, {8'h01 << i, i == 0 ? 3'h7 : 3'h7 & ~(3'h1 << ((i - 1) / 2))});
    end
    host.setMode(1'h0);
    repeat (3) @(posedge mclk);
    #1;
    chk({activeSupTest, activeAmpTest}, 16'h0000);
    fault(10'h000, 5'h02, 5'h02, 2'h2, 6'h00);
    fault(10'h002, 5'h02, 5'h02, 2'h0, 6'h00);
    fault(10'h004, 5'h02, 5'h02, 2'h0, 6'h3f);
    fault(10'h006, 5'h02, 5'h02, 2'h1, 6'h3f);
    fault(10'h00c, 5'h02, 5'h02, 2'h0, 6'h38);
    fault(10'h00e, 5'h02, 5'h02, 2'h1, 6'h38);
    fault(10'h000, 5'h04, 5'h10, 2'h2, 6'h00);
    fault(10'h010, 5'h04, 5'h10, 2'h0, 6'h00);
    fault(10'h020, 5'h04, 5'h10, 2'h0, 6'h08);
    fault(10'h030, 5'h04, 5'h10, 2'h1, 6'h08);
    fault(10'h000, 5'h01, 5'h01, 2'h0, 6'h00);
    fault(10'h001, 5'h01, 5'h01, 2'h1, 6'h3f);
    fault(10'h012, 5'h06, 5'h12, 2'h0, 6'h00);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    conclude;
  end
endmodule // test_frs_fault_reaction
